// *** sor_pkg.sv ***
package sor_pkg;

	// ************************************************************
	// device spaces and storage sizes
	// ************************************************************
	localparam int MAIN_IO = 8;
	localparam int EXT_IO = 48;
	localparam int X_BITS = 56;
	localparam int Y_BITS = 56;
	localparam int M_BITS = 512;
	localparam int SPACE_W = 512;
	localparam int CELLS = 32;
	localparam int FILE_BASE = 16;
	localparam int M_KEEP_BASE = 100;
	localparam int IDX_REGS = 8;
	localparam int NIB = 4;
	localparam logic [3:0] MAX_N16 = 4'h4;
	localparam logic [3:0] MAX_N32 = 4'h8;
	localparam logic [6:0] MAX_FUNC = 7'h5D;
	localparam logic [6:0] FUNC_COPY_WORD = 7'h0C;

	// ************************************************************
	// encodings
	// ************************************************************
	typedef enum logic [3:0] {
		OP_IDLE_STEP = 4'h0,
		OP_LOAD_OPEN = 4'h1,
		OP_LOAD_CLOSED = 4'h2,
		OP_SERIES_OPEN = 4'h3,
		OP_SERIES_CLOSED = 4'h4,
		OP_PARALLEL_OPEN = 4'h5,
		OP_PARALLEL_CLOSED = 4'h6,
		OP_SERIES_BLOCK = 4'h7,
		OP_PARALLEL_BLOCK = 4'h8,
		OP_LATCH_ON = 4'h9,
		OP_LATCH_OFF = 4'hA,
		OP_FUNCTION = 4'hB
	} sor_op_t;

	typedef enum logic [2:0] {
		K_CONST = 3'h0,
		K_BIT = 3'h1,
		K_GROUP = 3'h2,
		K_CELL = 3'h3,
		K_SHORT = 3'h4,
		K_LONG = 3'h5,
		K_LABEL = 3'h6
	} sor_kind_t;

	typedef enum logic [1:0] {S_X = 2'h0, S_Y = 2'h1, S_M = 2'h2} sor_space_t;
	typedef enum logic [1:0] {I_NONE = 2'h0, I_SHORT = 2'h1, I_LONG = 2'h2} sor_idx_t;

	typedef enum logic [2:0] {
		F_NONE = 3'h0,
		F_COUNT = 3'h1,
		F_INDEX = 3'h2,
		F_ADDR = 3'h3,
		F_CONST = 3'h4,
		F_FUNC = 3'h5,
		F_KIND = 3'h6,
		F_STACK = 3'h7
	} sor_fault_t;

	typedef enum logic {ST_CLEAR = 1'b0, ST_RUN = 1'b1} sor_state_t;

	// ************************************************************
	// shared decoding
	// ************************************************************
	function automatic logic sor_count_ok(input logic [3:0] n, input logic wide);
		sor_count_ok = (n != 4'h0) && (n <= (wide ? MAX_N32 : MAX_N16));
	endfunction : sor_count_ok

	function automatic logic [31:0] sor_space_size(input sor_space_t s);
		case (s)
			S_X: sor_space_size = 32'(X_BITS);
			S_Y: sor_space_size = 32'(Y_BITS);
			default: sor_space_size = 32'(M_BITS);
		endcase
	endfunction : sor_space_size

	function automatic logic sor_group_ok(input logic [31:0] head, input logic [3:0] n,
		input sor_space_t s);
		sor_group_ok = (head < sor_space_size(s)) &&
			((head + 32'(n) * 32'(NIB)) <= sor_space_size(s));
	endfunction : sor_group_ok

	function automatic logic sor_cell_ok(input logic [31:0] e, input logic wide);
		sor_cell_ok = (e < 32'(CELLS)) && (!wide || (e + 32'h1) < 32'(CELLS));
	endfunction : sor_cell_ok

endpackage : sor_pkg

// *** sor_index_unit.sv ***
`timescale 1ns/1ps
module sor_index_unit (
	input logic [9:0] number,
	input logic [3:0] elem,
	input logic [3:0] count,
	input sor_pkg::sor_kind_t kind,
	input sor_pkg::sor_idx_t idx_mode,
	input logic [2:0] idx_sel,
	input logic [7:0][15:0] short_regs,
	input logic [7:0][31:0] long_regs,
	output logic [31:0] eff,
	output logic bad_index
);
	logic [31:0] offset;
	logic [31:0] step;

	always_comb begin
		case (idx_mode)
			sor_pkg::I_SHORT: offset = {{16{short_regs[idx_sel][15]}}, short_regs[idx_sel]};
			sor_pkg::I_LONG: offset = long_regs[idx_sel];
			default: offset = 32'h0000_0000;
		endcase
		// series walk: groups move by whole nibbles so no bit is skipped
		if (kind == sor_pkg::K_GROUP) begin
			step = 32'(elem) * 32'(count) * 32'(sor_pkg::NIB);
		end else begin
			step = 32'(elem);
		end
		eff = 32'(number) + offset + step;
		// offset registers and labels carry no index of their own
		bad_index = (idx_mode != sor_pkg::I_NONE) && ((kind == sor_pkg::K_LABEL) ||
			(kind == sor_pkg::K_SHORT) || (kind == sor_pkg::K_LONG) ||
			(kind == sor_pkg::K_CONST));
	end
endmodule : sor_index_unit

// *** sor_nibble_unit.sv ***
`timescale 1ns/1ps
module sor_nibble_unit (
	input logic [sor_pkg::SPACE_W-1:0] bits,
	input logic [31:0] head,
	input logic [3:0] count,
	input logic wide,
	output logic [31:0] value,
	output logic bad_count
);
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_bit
			logic [31:0] pos;
			logic take;
			assign pos = head + 32'(g);
			assign take = (32'(g) < 32'(count) * 32'(sor_pkg::NIB)) && (pos < 32'(sor_pkg::SPACE_W));
			// digits beyond the count read as zero
			assign value[g] = take && bits[pos[8:0]];
		end
	endgenerate

	assign bad_count = !sor_pkg::sor_count_ok(count, wide);
endmodule : sor_nibble_unit

// *** sor_resolver.sv ***
`timescale 1ns/1ps
module sor_resolver (
	input logic clk,
	input logic arst_n,
	input logic step_valid,
	input sor_pkg::sor_op_t step_op,
	input logic [6:0] step_func,
	input logic step_wide,
	input logic [3:0] step_elem,
	input sor_pkg::sor_kind_t src_kind,
	input sor_pkg::sor_space_t src_space,
	input logic [9:0] src_number,
	input logic [3:0] src_count,
	input sor_pkg::sor_idx_t src_idx_mode,
	input logic [2:0] src_idx_sel,
	input logic [31:0] src_const,
	input sor_pkg::sor_kind_t dst_kind,
	input sor_pkg::sor_space_t dst_space,
	input logic [9:0] dst_number,
	input logic [3:0] dst_count,
	input sor_pkg::sor_idx_t dst_idx_mode,
	input logic [2:0] dst_idx_sel,
	input logic [7:0] x_main,
	input logic [47:0] x_ext,
	input logic [4:0] file_cell_count,
	output logic step_done,
	output logic step_fault,
	output sor_pkg::sor_fault_t fault_code,
	output logic logic_result,
	output logic [31:0] copy_value,
	output logic [7:0] y_main,
	output logic [47:0] y_ext
);

	// ************************************************************
	// storage
	// ************************************************************
	sor_pkg::sor_state_t state, next_state;
	logic [sor_pkg::Y_BITS-1:0] y_bits, next_y;
	logic [sor_pkg::M_BITS-1:0] m_bits, next_m;
	logic [sor_pkg::CELLS-1:0][15:0] cells, next_cells;
	logic [7:0][15:0] short_regs, next_short;
	logic [7:0][31:0] long_regs, next_long;
	logic acc, next_acc;
	logic [7:0] stk, next_stk;
	logic [3:0] depth, next_depth;
	logic chain, next_chain;
	logic next_done, next_fault;
	sor_pkg::sor_fault_t next_code;
	logic [31:0] next_copy;

	// ************************************************************
	// operand resolution
	// ************************************************************
	logic [sor_pkg::X_BITS-1:0] x_bits;
	logic [sor_pkg::SPACE_W-1:0] src_bits;
	logic [31:0] src_eff, dst_eff, nib_val, src_val, wpos;
	logic src_bad_idx, dst_bad_idx, nib_bad, src_bit, drive;
	logic [4:0] src_cell, dst_cell;
	sor_pkg::sor_fault_t src_flt, dst_flt, flt;

	// extension points follow the main unit, nearest block lowest
	assign x_bits = {x_ext, x_main};

	sor_index_unit u_src_index (
		.number(src_number),
		.elem(step_elem),
		.count(src_count),
		.kind(src_kind),
		.idx_mode(src_idx_mode),
		.idx_sel(src_idx_sel),
		.short_regs(short_regs),
		.long_regs(long_regs),
		.eff(src_eff),
		.bad_index(src_bad_idx)
	);

	sor_index_unit u_dst_index (
		.number(dst_number),
		.elem(step_elem),
		.count(dst_count),
		.kind(dst_kind),
		.idx_mode(dst_idx_mode),
		.idx_sel(dst_idx_sel),
		.short_regs(short_regs),
		.long_regs(long_regs),
		.eff(dst_eff),
		.bad_index(dst_bad_idx)
	);

	sor_nibble_unit u_src_nibble (
		.bits(src_bits),
		.head(src_eff),
		.count(src_count),
		.wide(step_wide),
		.value(nib_val),
		.bad_count(nib_bad)
	);

	assign src_cell = src_eff[4:0];
	assign dst_cell = dst_eff[4:0];

	always_comb begin
		case (src_space)
			sor_pkg::S_X: src_bits = sor_pkg::SPACE_W'(x_bits);
			sor_pkg::S_Y: src_bits = sor_pkg::SPACE_W'(y_bits);
			default: src_bits = m_bits;
		endcase
	end

	// source side: read only, never written back
	always_comb begin
		src_val = 32'h0000_0000;
		src_bit = 1'b0;
		src_flt = sor_pkg::F_NONE;
		if (src_bad_idx) begin
			src_flt = sor_pkg::F_INDEX;
		end else begin
			case (src_kind)
				sor_pkg::K_CONST: src_val = src_const;
				sor_pkg::K_BIT: begin
					if (src_eff < sor_pkg::sor_space_size(src_space)) begin
						src_bit = src_bits[src_eff[8:0]];
					end else begin
						src_flt = sor_pkg::F_ADDR;
					end
				end
				sor_pkg::K_GROUP: begin
					if (nib_bad) begin
						src_flt = sor_pkg::F_COUNT;
					end else if (!sor_pkg::sor_group_ok(src_eff, src_count, src_space)) begin
						src_flt = sor_pkg::F_ADDR;
					end else begin
						src_val = nib_val;
					end
				end
				sor_pkg::K_CELL: begin
					if (!sor_pkg::sor_cell_ok(src_eff, step_wide)) begin
						src_flt = sor_pkg::F_ADDR;
					end else if (step_wide) begin
						src_val = {cells[src_cell + 5'h01], cells[src_cell]};
					end else begin
						src_val = {16'h0000, cells[src_cell]};
					end
				end
				sor_pkg::K_SHORT: begin
					if (src_number >= 10'(sor_pkg::IDX_REGS)) src_flt = sor_pkg::F_ADDR;
					else src_val = {16'h0000, short_regs[src_number[2:0]]};
				end
				sor_pkg::K_LONG: begin
					if (src_number >= 10'(sor_pkg::IDX_REGS)) src_flt = sor_pkg::F_ADDR;
					else src_val = long_regs[src_number[2:0]];
				end
				default: src_flt = sor_pkg::F_KIND;
			endcase
		end
		// a 16-bit operation only ever sees the low half
		if (!step_wide) begin
			src_val[31:16] = 16'h0000;
		end
	end

	// destination side checks
	always_comb begin
		dst_flt = sor_pkg::F_NONE;
		if (dst_bad_idx) begin
			dst_flt = sor_pkg::F_INDEX;
		end else begin
			case (dst_kind)
				sor_pkg::K_CONST: dst_flt = sor_pkg::F_CONST;
				sor_pkg::K_BIT: begin
					if (dst_space == sor_pkg::S_X) dst_flt = sor_pkg::F_KIND;
					else if (dst_eff >= sor_pkg::sor_space_size(dst_space)) dst_flt = sor_pkg::F_ADDR;
				end
				sor_pkg::K_GROUP: begin
					if (dst_space == sor_pkg::S_X) dst_flt = sor_pkg::F_KIND;
					else if (!sor_pkg::sor_count_ok(dst_count, step_wide)) dst_flt = sor_pkg::F_COUNT;
					else if (!sor_pkg::sor_group_ok(dst_eff, dst_count, dst_space))
						dst_flt = sor_pkg::F_ADDR;
				end
				sor_pkg::K_CELL: begin
					if (!sor_pkg::sor_cell_ok(dst_eff, step_wide)) dst_flt = sor_pkg::F_ADDR;
				end
				sor_pkg::K_SHORT, sor_pkg::K_LONG: begin
					if (dst_number >= 10'(sor_pkg::IDX_REGS)) dst_flt = sor_pkg::F_ADDR;
				end
				default: dst_flt = sor_pkg::F_KIND;
			endcase
		end
	end

	// with no contact since the last reset the coil is driven directly
	assign drive = chain ? acc : 1'b1;

	// ************************************************************
	// step execution
	// ************************************************************
	always_comb begin
		next_state = state;
		next_y = y_bits;
		next_m = m_bits;
		next_cells = cells;
		next_short = short_regs;
		next_long = long_regs;
		next_acc = acc;
		next_stk = stk;
		next_depth = depth;
		next_chain = chain;
		next_done = 1'b0;
		next_fault = 1'b0;
		next_code = sor_pkg::F_NONE;
		next_copy = copy_value;
		flt = sor_pkg::F_NONE;
		wpos = 32'h0000_0000;
		if (state == sor_pkg::ST_CLEAR) begin
			// retained file cells and latched flags keep their contents
			for (int i = 0; i < sor_pkg::CELLS; i++) begin
				if (i < sor_pkg::FILE_BASE || i >= sor_pkg::FILE_BASE + int'(file_cell_count)) begin
					next_cells[i] = 16'h0000;
				end
			end
			for (int i = 0; i < sor_pkg::M_KEEP_BASE; i++) begin
				next_m[i] = 1'b0;
			end
			next_state = sor_pkg::ST_RUN;
		end else if (step_valid) begin
			next_done = 1'b1;
			case (step_op)
				sor_pkg::OP_IDLE_STEP: flt = sor_pkg::F_NONE;
				sor_pkg::OP_LOAD_OPEN, sor_pkg::OP_LOAD_CLOSED: begin
					if (src_kind != sor_pkg::K_BIT) flt = sor_pkg::F_KIND;
					else if (src_flt != sor_pkg::F_NONE) flt = src_flt;
					else if (chain && depth == 4'h8) flt = sor_pkg::F_STACK;
					else begin
						// a new start parks the running result for a block join
						if (chain) begin
							next_stk = {stk[6:0], acc};
							next_depth = depth + 4'h1;
						end
						next_acc = src_bit ^ (step_op == sor_pkg::OP_LOAD_CLOSED);
						next_chain = 1'b1;
					end
				end
				sor_pkg::OP_SERIES_OPEN, sor_pkg::OP_SERIES_CLOSED,
				sor_pkg::OP_PARALLEL_OPEN, sor_pkg::OP_PARALLEL_CLOSED: begin
					if (src_kind != sor_pkg::K_BIT) flt = sor_pkg::F_KIND;
					else if (src_flt != sor_pkg::F_NONE) flt = src_flt;
					else if (step_op == sor_pkg::OP_SERIES_OPEN) next_acc = acc & src_bit;
					else if (step_op == sor_pkg::OP_SERIES_CLOSED) next_acc = acc & ~src_bit;
					else if (step_op == sor_pkg::OP_PARALLEL_OPEN) next_acc = acc | src_bit;
					else next_acc = acc | ~src_bit;
				end
				sor_pkg::OP_SERIES_BLOCK, sor_pkg::OP_PARALLEL_BLOCK: begin
					if (depth == 4'h0) flt = sor_pkg::F_STACK;
					else begin
						next_acc = (step_op == sor_pkg::OP_SERIES_BLOCK) ?
							(acc & stk[0]) : (acc | stk[0]);
						next_stk = {1'b0, stk[7:1]};
						next_depth = depth - 4'h1;
					end
				end
				sor_pkg::OP_LATCH_ON, sor_pkg::OP_LATCH_OFF: begin
					if (dst_kind != sor_pkg::K_BIT) flt = sor_pkg::F_KIND;
					else if (dst_flt != sor_pkg::F_NONE) flt = dst_flt;
					else if (drive) begin
						// the relay holds until the opposite coil is driven
						if (dst_space == sor_pkg::S_Y) begin
							next_y[dst_eff[5:0]] = (step_op == sor_pkg::OP_LATCH_ON);
						end else begin
							next_m[dst_eff[8:0]] = (step_op == sor_pkg::OP_LATCH_ON);
						end
					end
				end
				sor_pkg::OP_FUNCTION: begin
					if (step_func > sor_pkg::MAX_FUNC) flt = sor_pkg::F_FUNC;
					else if (step_func == sor_pkg::FUNC_COPY_WORD && drive) begin
						if (src_kind == sor_pkg::K_BIT || src_kind == sor_pkg::K_LABEL) flt = sor_pkg::F_KIND;
						else if (src_flt != sor_pkg::F_NONE) flt = src_flt;
						else if (dst_kind == sor_pkg::K_BIT) flt = sor_pkg::F_KIND;
						else if (dst_flt != sor_pkg::F_NONE) flt = dst_flt;
						else begin
							next_copy = src_val;
							case (dst_kind)
								sor_pkg::K_GROUP: begin
									for (int g = 0; g < 32; g++) begin
										// only the digits named are stored
										if (32'(g) < 32'(dst_count) * 32'(sor_pkg::NIB)) begin
											wpos = dst_eff + 32'(g);
											if (dst_space == sor_pkg::S_Y) next_y[wpos[5:0]] = src_val[g];
											else next_m[wpos[8:0]] = src_val[g];
										end
									end
								end
								sor_pkg::K_CELL: begin
									next_cells[dst_cell] = src_val[15:0];
									if (step_wide) next_cells[dst_cell + 5'h01] = src_val[31:16];
								end
								sor_pkg::K_SHORT: next_short[dst_number[2:0]] = src_val[15:0];
								default: next_long[dst_number[2:0]] = src_val;
							endcase
						end
					end
				end
				default: flt = sor_pkg::F_KIND;
			endcase
			if (flt != sor_pkg::F_NONE) begin
				// a faulted step leaves every device untouched
				next_y = y_bits;
				next_m = m_bits;
				next_cells = cells;
				next_short = short_regs;
				next_long = long_regs;
				next_acc = acc;
				next_stk = stk;
				next_depth = depth;
				next_chain = chain;
				next_copy = copy_value;
				next_fault = 1'b1;
				next_code = flt;
			end
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= sor_pkg::ST_CLEAR;
			y_bits <= '0;
			short_regs <= '0;
			long_regs <= '0;
			acc <= 1'b0;
			stk <= 8'h00;
			depth <= 4'h0;
			chain <= 1'b0;
			step_done <= 1'b0;
			step_fault <= 1'b0;
			fault_code <= sor_pkg::F_NONE;
			copy_value <= 32'h0000_0000;
		end else begin
			state <= next_state;
			y_bits <= next_y;
			short_regs <= next_short;
			long_regs <= next_long;
			acc <= next_acc;
			stk <= next_stk;
			depth <= next_depth;
			chain <= next_chain;
			step_done <= next_done;
			step_fault <= next_fault;
			fault_code <= next_code;
			copy_value <= next_copy;
		end
	end

	// backed storage: no reset, the clear pass trims the volatile part
	always_ff @(posedge clk) begin
		cells <= next_cells;
		m_bits <= next_m;
	end

	assign logic_result = acc;
	assign y_main = y_bits[sor_pkg::MAIN_IO-1:0];
	assign y_ext = y_bits[sor_pkg::Y_BITS-1:sor_pkg::MAIN_IO];

endmodule : sor_resolver

// *** sor_resolver_sva.sv ***
`timescale 1ns/1ps
module sor_resolver_sva (
	input logic clk,
	input logic arst_n,
	input logic step_valid,
	input sor_pkg::sor_op_t step_op,
	input logic [6:0] step_func,
	input sor_pkg::sor_kind_t src_kind,
	input sor_pkg::sor_space_t src_space,
	input logic [9:0] src_number,
	input logic [3:0] src_count,
	input sor_pkg::sor_idx_t src_idx_mode,
	input logic [7:0] x_main,
	input logic step_done,
	input logic step_fault,
	input sor_pkg::sor_fault_t fault_code,
	input logic logic_result,
	input logic [31:0] copy_value,
	input logic [7:0] y_main
);
	logic run, next_run, want, next_want;

	// first edge after release is the clearing pass, steps there are ignored
	always_comb begin
		next_run = 1'b1;
		next_want = x_main[src_number[2:0]] ^ (step_op == sor_pkg::OP_LOAD_CLOSED);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run <= 1'b0;
			want <= 1'b0;
		end else begin
			run <= next_run;
			want <= next_want;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_take;
		step_valid && run;
	endsequence
	sequence s_func;
		s_take ##0 step_op == sor_pkg::OP_FUNCTION;
	endsequence

	a_step_answered: assert property (s_take |=> step_done)
		else $error("step not answered");
	a_no_stray_done: assert property (!(step_valid && run) |=> !step_done)
		else $error("done without step");
	a_fault_coded: assert property (step_fault |-> step_done && fault_code != sor_pkg::F_NONE)
		else $error("fault without code");
	a_clean_code: assert property (step_done && !step_fault |-> fault_code == sor_pkg::F_NONE)
		else $error("code without fault");
	a_bad_count: assert property (s_func ##0 step_func == sor_pkg::FUNC_COPY_WORD && logic_result
		&& src_kind == sor_pkg::K_GROUP && (src_count == 4'h0 || src_count == 4'h9) |=> step_fault)
		else $error("bad digit count accepted");
	a_func_range: assert property (s_func ##0 step_func > sor_pkg::MAX_FUNC && logic_result
		|=> fault_code == sor_pkg::F_FUNC)
		else $error("function number out of range accepted");
	a_func_accepted: assert property (s_func ##0 step_func <= sor_pkg::MAX_FUNC
		&& step_func != sor_pkg::FUNC_COPY_WORD |=> !step_fault && $stable(copy_value))
		else $error("valid function number rejected");
	a_idle_step: assert property (s_take ##0 step_op == sor_pkg::OP_IDLE_STEP
		|=> !step_fault && $stable(y_main) && $stable(logic_result) && $stable(copy_value))
		else $error("idle step changed state");
	a_contact_sample: assert property (s_take ##0 (step_op == sor_pkg::OP_LOAD_OPEN
		|| step_op == sor_pkg::OP_LOAD_CLOSED) && src_kind == sor_pkg::K_BIT
		&& src_space == sor_pkg::S_X && src_idx_mode == sor_pkg::I_NONE && src_number < 10'h8
		|=> logic_result == want)
		else $error("load contact result wrong");
	a_latch_only: assert property (!(step_valid && run && (step_op == sor_pkg::OP_LATCH_ON
		|| step_op == sor_pkg::OP_FUNCTION)) |=> (y_main & ~$past(y_main)) == 8'h00)
		else $error("output set without latch");
endmodule : sor_resolver_sva

// *** sor_resolver_test.sv ***
`timescale 1ns/1ps
module sor_resolver_test;
	localparam sor_pkg::sor_kind_t KC = sor_pkg::K_CONST;
	localparam sor_pkg::sor_kind_t KB = sor_pkg::K_BIT;
	localparam sor_pkg::sor_kind_t KG = sor_pkg::K_GROUP;
	localparam sor_pkg::sor_kind_t KL = sor_pkg::K_CELL;
	localparam sor_pkg::sor_fault_t OK = sor_pkg::F_NONE;
	logic clk, arst_n, step_valid, step_wide, step_done, step_fault, logic_result, acc;
	sor_pkg::sor_op_t step_op, op;
	logic [6:0] step_func, w_func;
	logic [3:0] step_elem, src_count, dst_count, w_elem;
	sor_pkg::sor_kind_t src_kind, dst_kind;
	sor_pkg::sor_space_t src_space, dst_space, w_ds;
	logic [9:0] src_number, dst_number;
	sor_pkg::sor_idx_t src_idx_mode, dst_idx_mode, w_sm;
	logic [2:0] src_idx_sel, dst_idx_sel, w_sel;
	logic [31:0] src_const, copy_value, cv, c, w_const;
	logic [7:0] x_main, y_main;
	logic [47:0] x_ext, y_ext;
	logic [4:0] file_cell_count;
	sor_pkg::sor_fault_t fault_code;
	logic [55:0] xb, ym;
	logic w_wide;
	int seed, failures, checked, n, h, e;

	sor_resolver dut (.clk, .arst_n, .step_valid, .step_op, .step_func, .step_wide, .step_elem,
		.src_kind, .src_space, .src_number, .src_count, .src_idx_mode, .src_idx_sel, .src_const,
		.dst_kind, .dst_space, .dst_number, .dst_count, .dst_idx_mode, .dst_idx_sel, .x_main,
		.x_ext, .file_cell_count, .step_done, .step_fault, .fault_code, .logic_result,
		.copy_value, .y_main, .y_ext);

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic cmp_val(input string what, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask : cmp_val

	task automatic report_and_stop;
		if (failures == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	function automatic logic [31:0] grp(input logic [55:0] b, input int hd, input int cnt);
		grp = '0;
		for (int g = 0; g < 4 * cnt; g++) grp[g] = b[hd + g];
	endfunction : grp

	// answer is registered on the taking edge and read 1 ns after it
	task automatic run_step(input sor_pkg::sor_op_t o, input sor_pkg::sor_kind_t sk,
		input int sn, input int sc, input sor_pkg::sor_kind_t dk, input int dn, input int dc,
		input sor_pkg::sor_fault_t ef);
		@(posedge clk);
		step_valid <= 1'b1;
		step_op <= o;
		step_func <= w_func;
		step_wide <= w_wide;
		step_elem <= w_elem;
		src_kind <= sk;
		src_space <= sor_pkg::S_X;
		{src_number, src_count} <= {10'(sn), 4'(sc)};
		src_idx_mode <= w_sm;
		{src_idx_sel, src_const} <= {w_sel, w_const};
		dst_kind <= dk;
		dst_space <= w_ds;
		{dst_number, dst_count} <= {10'(dn), 4'(dc)};
		@(posedge clk);
		step_valid <= 1'b0;
		#1;
		cmp_val("done", {1'b1, ef != OK, ef}, {step_done, step_fault, fault_code});
		{w_func, w_wide, w_elem, w_sel} = {7'h0C, 1'b0, 4'h0, 3'h0};
		w_sm = sor_pkg::I_NONE;
		w_ds = sor_pkg::S_X;
	endtask : run_step

	task automatic cp(input sor_pkg::sor_kind_t sk, input int sn, input int sc,
		input sor_pkg::sor_kind_t dk, input int dn, input int dc, input sor_pkg::sor_fault_t ef);
		run_step(sor_pkg::OP_FUNCTION, sk, sn, sc, dk, dn, dc, ef);
	endtask : cp

	task automatic lt(input sor_pkg::sor_op_t o, input int sn);
		run_step(sor_pkg::OP_LOAD_OPEN, KB, sn, 0, KC, 0, 0, OK);
		w_ds = sor_pkg::S_Y;
		run_step(o, KC, 0, 0, KB, 7, 0, OK);
		cmp_val("y", 64'(ym), 64'({y_ext, y_main}));
	endtask : lt

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		report_and_stop();
	end

	initial begin
		{seed, failures, checked, ym} = {32'd36829, 32'd0, 32'd0, 56'h0};
		{arst_n, step_valid, step_func, step_wide, step_elem} = '0;
		{src_number, src_count, src_idx_sel, src_const} = '0;
		{dst_number, dst_count, dst_idx_sel} = '0;
		step_op = sor_pkg::OP_IDLE_STEP;
		src_kind = KC;
		dst_kind = KC;
		src_space = sor_pkg::S_X;
		dst_space = sor_pkg::S_X;
		src_idx_mode = sor_pkg::I_NONE;
		dst_idx_mode = sor_pkg::I_NONE;
		w_sm = sor_pkg::I_NONE;
		w_ds = sor_pkg::S_X;
		{x_main, x_ext, file_cell_count} = {56'h0, 5'h10};
		{w_func, w_wide, w_elem, w_sel, w_const} = {7'h0C, 8'h0, 32'h0};
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		w_const = 32'h0001_2345;
		cp(KC, 0, 0, KL, 3, 0, OK);
		cmp_val("copy_value", 64'h2345, 64'(copy_value));
		c = $random(seed);
		{w_const, w_wide} = {c, 1'b1};
		cp(KC, 0, 0, KL, 4, 0, OK);
		cp(KL, 5, 0, KL, 0, 0, OK);
		cmp_val("copy_value", 64'(c[31:16]), 64'(copy_value));
		w_wide = 1'b1;
		cp(KL, 4, 0, KL, 6, 0, OK);
		cmp_val("copy_value", 64'(c), 64'(copy_value));
		w_elem = 4'h1;
		cp(KL, 3, 0, KL, 0, 0, OK);
		cmp_val("copy_value", 64'(c[15:0]), 64'(copy_value));
		w_const = 32'h3;
		cp(KC, 0, 0, sor_pkg::K_SHORT, 1, 0, OK);
		cp(sor_pkg::K_SHORT, 1, 0, KL, 0, 0, OK);
		cmp_val("copy_value", 64'h3, 64'(copy_value));
		w_sm = sor_pkg::I_SHORT;
		w_sel = 3'h1;
		cp(KL, 1, 0, KL, 0, 0, OK);
		cmp_val("copy_value", 64'(c[15:0]), 64'(copy_value));
		{w_const, w_wide} = {32'h2, 1'b1};
		cp(KC, 0, 0, sor_pkg::K_LONG, 2, 0, OK);
		w_sm = sor_pkg::I_LONG;
		{w_sel, w_wide} = {3'h2, 1'b1};
		cp(KL, 2, 0, KL, 0, 0, OK);
		cmp_val("copy_value", 64'(c), 64'(copy_value));
		w_sm = sor_pkg::I_SHORT;
		w_sel = 3'h1;
		cp(KC, 0, 0, KL, 0, 0, sor_pkg::F_INDEX);
		cp(KL, 4, 0, KL, 0, 0, OK);
		cmp_val("copy_value", 64'(c[15:0]), 64'(copy_value));
		cp(KC, 0, 0, KC, 0, 0, sor_pkg::F_CONST);
		// group sources: heads and data random, counts 1 and 3 at 16 bits, 2, 4, 6 and 8 at 32 bits
		for (int i = 0; i < 20; i++) begin
			xb = 56'({$random(seed), $random(seed)});
			@(posedge clk);
			{x_ext, x_main} <= xb;
			w_wide = i[0];
			n = w_wide ? 1 + i % 8 : 1 + i % 4;
			e = n <= 4 ? i / 2 % 2 : 0;
			h = $unsigned($random(seed)) % (57 - 4 * n * (e + 1));
			w_elem = 4'(e);
			cp(KG, h, n, KL, 0, 0, OK);
			cmp_val("group", 64'(grp(xb, h + 4 * n * e, n)), 64'(copy_value));
		end
		for (int i = 0; i < 12; i++) begin
			n = i < 4 ? i + 1 : i - 3;
			h = $unsigned($random(seed)) % (57 - 4 * n);
			c = $random(seed);
			{w_const, w_wide} = {c, i >= 4};
			w_ds = sor_pkg::S_Y;
			cp(KC, 0, 0, KG, h, n, OK);
			for (int g = 0; g < 4 * n; g++) ym[h + g] = c[g];
			cmp_val("y", 64'(ym), 64'({y_ext, y_main}));
		end
		xb[7:0] = 8'($random(seed));
		@(posedge clk);
		x_main <= xb[7:0];
		acc = xb[0];
		run_step(sor_pkg::OP_LOAD_OPEN, KB, 0, 0, KC, 0, 0, OK);
		for (int i = 0; i < 16; i++) begin
			op = sor_pkg::sor_op_t'(4'(3 + i % 4));
			h = $unsigned($random(seed)) % 8;
			e = xb[h] ^ (op == sor_pkg::OP_SERIES_CLOSED || op == sor_pkg::OP_PARALLEL_CLOSED);
			acc = op <= sor_pkg::OP_SERIES_CLOSED ? acc & e[0] : acc | e[0];
			run_step(op, KB, h, 0, KC, 0, 0, OK);
			cmp_val("logic_result", 64'(acc), 64'(logic_result));
		end
		run_step(sor_pkg::OP_LOAD_CLOSED, KB, 1, 0, KC, 0, 0, OK);
		run_step(sor_pkg::OP_PARALLEL_BLOCK, KC, 0, 0, KC, 0, 0, OK);
		acc = acc | !xb[1];
		cmp_val("logic_result", 64'(acc), 64'(logic_result));
		run_step(sor_pkg::OP_LOAD_OPEN, KB, 2, 0, KC, 0, 0, OK);
		run_step(sor_pkg::OP_SERIES_BLOCK, KC, 0, 0, KC, 0, 0, OK);
		acc = acc & xb[2];
		cmp_val("logic_result", 64'(acc), 64'(logic_result));
		@(posedge clk);
		x_main <= 8'h01;
		ym[7] = 1'b0;
		lt(sor_pkg::OP_LATCH_OFF, 0);
		ym[7] = 1'b1;
		lt(sor_pkg::OP_LATCH_ON, 0);
		lt(sor_pkg::OP_LATCH_OFF, 1);
		run_step(sor_pkg::OP_LOAD_OPEN, KB, 0, 0, KC, 0, 0, OK);
		cv = copy_value;
		for (int i = 0; i < 4; i++) begin
			w_wide = i[1];
			cp(KG, 0, i[0] ? (i[1] ? 9 : 5) : 0, KL, 0, 0, sor_pkg::F_COUNT);
			cmp_val("copy_value", 64'(cv), 64'(copy_value));
		end
		for (int i = 0; i < 8; i++) begin
			w_func = 7'(94 + $unsigned($random(seed)) % 34);
			cp(KC, 0, 0, KL, 0, 0, sor_pkg::F_FUNC);
			w_func = 7'($unsigned($random(seed)) % 94);
			w_func = w_func == sor_pkg::FUNC_COPY_WORD ? 7'h00 : w_func;
			w_const = $random(seed);
			cp(KC, 0, 0, KL, 0, 0, OK);
			cmp_val("copy_value", 64'(cv), 64'(copy_value));
		end
		run_step(sor_pkg::OP_IDLE_STEP, KC, 0, 0, KC, 0, 0, OK);
		cmp_val("y", 64'(ym), 64'({y_ext, y_main}));
		// a second reset: file cells past the retained count are cleared
		{w_const, w_wide} = {32'h5A5A_A5C3, 1'b1};
		cp(KC, 0, 0, KL, 16, 0, OK);
		@(posedge clk);
		arst_n <= 1'b0;
		file_cell_count <= 5'h01;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		w_wide = 1'b1;
		cp(KL, 16, 0, KL, 0, 0, OK);
		cmp_val("copy_value", 64'h0000_A5C3, 64'(copy_value));
		report_and_stop();
	end
endmodule : sor_resolver_test

bind sor_resolver sor_resolver_sva chk (.clk, .arst_n, .step_valid, .step_op, .step_func,
	.src_kind, .src_space, .src_number, .src_count, .src_idx_mode, .x_main, .step_done,
	.step_fault, .fault_code, .logic_result, .copy_value, .y_main);
